// *** ufc_pkg.sv ***
// Purpose: Constants for the serial port queue and line control block
// Assumes: 40 MHz system clock, AXI4-Lite register access, 8N1 framing
// Notes: Register offsets are byte addresses on the 32-bit bus
// How it works
// - Queue control is write-only and shares its address with read-only interrupt ident.
// - Queue control bits 7:6 pick receive trigger level 1, 4, 8 or 14.
// - Writing 1 to bit 2 zeroes transmit queue counters, shifter kept; self-clearing.
// - Writing 1 to bit 1 zeroes receive queue counters, shifter kept; self-clearing.
// - Bit 0 set enables both queues; clearing it discards all queued bytes.
// - Any switch between queue mode and single-byte mode empties both queues.
// - Other queue control fields change only on writes that also carry bit 0 set.
// - Line format register reads back what software wrote.
// - Line format bit 7 set routes shared addresses to the divisor latches.
// - Line format bit 7 clear routes them to receive, transmit and irq enable.
// - Line format bit 6 set holds serial output low for a break.
// - Break bit only forces the output pin level, nothing else.
// - Transmitter keeps shifting internally while break forces the pin.
// - Interrupt ident bits 7:6 read as ones while queue mode is on.
// - Data-available interrupt follows receive fill against the trigger level in queue mode, against one byte in single-byte mode.
package ufc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int QUEUE_DEPTH = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_IDENT = 8'h08;
  localparam logic [7:0] OFS_LINE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam int QC_EN = 0;
  localparam int QC_RX_RST = 1;
  localparam int QC_TX_RST = 2;
  localparam int QC_TRIG_LO = 6;
  localparam int LF_BREAK = 6;
  localparam int LF_DIV_ACCESS = 7;
  localparam int IE_RX = 0;
  localparam int IE_TX = 1;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  localparam logic [2:0] ID_NONE = 3'h0;
  localparam logic [2:0] ID_RX_AVAIL = 3'h2;
  localparam logic [2:0] ID_TX_EMPTY = 3'h1;
  localparam int ST_RX_TRIG = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_OVR = 2;
  localparam int ST_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FRAME_BITS = 10;
  localparam int DATA_BITS = 8;
  typedef enum logic [2:0] {SEL_DATA, SEL_IRQ_EN, SEL_IDENT, SEL_LINE, SEL_STATUS, SEL_MASK,
    SEL_NONE} ufc_sel_t;
endpackage : ufc_pkg

// *** ufc_queue.sv ***
// Purpose: Byte queue built from flip-flops
// Assumes: Push ignored when full, pop ignored when empty
// Notes: Flush only zeroes pointers and count, contents stay
`timescale 1ns/100ps
module ufc_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] data_o,
  output logic [$clog2(DEPTH):0] count_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } ufc_queue_st_t;
  ufc_queue_st_t q;
  ufc_queue_st_t next_q;
  logic do_push;
  logic do_pop;

  always_comb begin
    next_q = q;
    do_push = push_i && !full_o;
    do_pop = pop_i && !empty_o;
    if (do_push) begin
      next_q.mem[q.wr] = data_i;
      next_q.wr = q.wr + AW'(1);
    end
    if (do_pop) begin
      next_q.rd = q.rd + AW'(1);
    end
    next_q.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush_i) begin
      next_q.rd = '0;
      next_q.wr = '0;
      next_q.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign data_o = q.mem[q.rd];
  assign count_o = q.cnt;
  assign full_o = (q.cnt == (AW+1)'(DEPTH));
  assign empty_o = (q.cnt == '0);
endmodule : ufc_queue

// *** ufc_top.sv ***
// Purpose: Serial port queue control, line format and break, AXI4-Lite slave
// Assumes: Bus inputs share SYS_CLK_I; serial input is asynchronous
// Notes: Fixed 8N1 framing, one bit per divisor count, no oversampling
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module ufc_top #(
  parameter int DEPTH = ufc_pkg::QUEUE_DEPTH
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [ufc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ufc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_OUT_PIN_O,
  output logic IRQ_O
);
  localparam int CW = $clog2(DEPTH) + 1;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ufc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS} ufc_rx_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ufc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic queue_enable_bit;
    logic [1:0] trig_sel;
    logic [7:0] line_format_reg;
    logic [3:0] irq_enable_reg;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [ufc_pkg::ST_W-1:0] status;
    logic [ufc_pkg::ST_W-1:0] mask;
    logic rx_level_d;
    logic tx_empty_d;
    ufc_tx_t tx_st;
    logic [ufc_pkg::FRAME_BITS-1:0] tx_sh;
    logic [3:0] tx_bits;
    logic [15:0] tx_bcnt;
    ufc_rx_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bits;
    logic [15:0] rx_bcnt;
    logic rx_s1;
    logic rx_s2;
    logic ser_out;
    logic irq;
  } ufc_st_t;
  ufc_st_t q;
  ufc_st_t next_q;

  logic tx_push, tx_pop, tx_flush, tx_full, tx_empty;
  logic rx_push, rx_pop, rx_flush, rx_full, rx_empty;
  logic [7:0] tx_data, rx_data;
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic [CW-1:0] trig;
  logic rx_level, wr_fire, rd_fire;
  logic [2:0] ident;
  logic [7:0] ident_reg;
  logic [15:0] div_eff;
  logic [ufc_pkg::ST_W-1:0] ev;
  logic [7:0] wd;
  ufc_pkg::ufc_sel_t wsel, rsel;

  function automatic ufc_pkg::ufc_sel_t reg_sel(input logic [ufc_pkg::ADDR_W-1:0] a);
    case (a)
      ufc_pkg::OFS_DATA: reg_sel = ufc_pkg::SEL_DATA;
      ufc_pkg::OFS_IRQ_EN: reg_sel = ufc_pkg::SEL_IRQ_EN;
      ufc_pkg::OFS_IDENT: reg_sel = ufc_pkg::SEL_IDENT;
      ufc_pkg::OFS_LINE: reg_sel = ufc_pkg::SEL_LINE;
      ufc_pkg::OFS_STATUS: reg_sel = ufc_pkg::SEL_STATUS;
      ufc_pkg::OFS_MASK: reg_sel = ufc_pkg::SEL_MASK;
      default: reg_sel = ufc_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  ufc_queue #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
    .clk_i(SYS_CLK_I), .rst_n_i(NRST_I), .flush_i(tx_flush), .push_i(tx_push),
    .data_i(q.w_data[7:0]), .pop_i(tx_pop), .data_o(tx_data), .count_o(tx_cnt),
    .full_o(tx_full), .empty_o(tx_empty)
  );
  ufc_queue #(.WIDTH(8), .DEPTH(DEPTH)) u_rxq (
    .clk_i(SYS_CLK_I), .rst_n_i(NRST_I), .flush_i(rx_flush), .push_i(rx_push),
    .data_i(q.rx_sh), .pop_i(rx_pop), .data_o(rx_data), .count_o(rx_cnt),
    .full_o(rx_full), .empty_o(rx_empty)
  );

  always_comb begin
    next_q = q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_flush = 1'b0;
    rx_flush = 1'b0;
    ev = '0;
    wd = q.w_data[7:0];
    wsel = reg_sel(q.aw_addr);
    rsel = reg_sel(S_AXI_ARADDR_I);
    case (q.trig_sel)
      2'b00: trig = CW'(ufc_pkg::TRIG_L0);
      2'b01: trig = CW'(ufc_pkg::TRIG_L1);
      2'b10: trig = CW'(ufc_pkg::TRIG_L2);
      default: trig = CW'(ufc_pkg::TRIG_L3);
    endcase
    // Single-byte mode behaves as a queue of depth one
    rx_level = q.queue_enable_bit ? (rx_cnt >= trig) : !rx_empty;
    if (rx_level && q.irq_enable_reg[ufc_pkg::IE_RX]) begin
      ident = ufc_pkg::ID_RX_AVAIL;
    end else if (tx_empty && q.irq_enable_reg[ufc_pkg::IE_TX]) begin
      ident = ufc_pkg::ID_TX_EMPTY;
    end else begin
      ident = ufc_pkg::ID_NONE;
    end
    ident_reg = {{2{q.queue_enable_bit}}, 2'b00, ident, ident == ufc_pkg::ID_NONE};
    div_eff = ({q.div_hi, q.div_lo} == 16'h0000) ? 16'h0001 : {q.div_hi, q.div_lo};
    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID_I && q.awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && q.wready) begin
      next_q.w_held = 1'b1;
      next_q.w_data = S_AXI_WDATA_I;
      next_q.w_strb = S_AXI_WSTRB_I;
    end
    if (q.bvalid && S_AXI_BREADY_I) begin
      next_q.bvalid = 1'b0;
    end
    wr_fire = q.aw_held && q.w_held && !q.bvalid;
    if (wr_fire) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = (wsel == ufc_pkg::SEL_NONE) ? ufc_pkg::RESP_SLVERR : ufc_pkg::RESP_OKAY;
      if (q.w_strb[0]) begin
        case (wsel)
          ufc_pkg::SEL_DATA: begin
            if (q.line_format_reg[ufc_pkg::LF_DIV_ACCESS]) begin
              next_q.div_lo = wd;
            end else begin
              tx_push = q.queue_enable_bit ? 1'b1 : tx_empty;
            end
          end
          ufc_pkg::SEL_IRQ_EN: begin
            if (q.line_format_reg[ufc_pkg::LF_DIV_ACCESS]) begin
              next_q.div_hi = wd;
            end else begin
              next_q.irq_enable_reg = wd[3:0];
            end
          end
          ufc_pkg::SEL_IDENT: begin
            // Bits 5:3 carry no function
            if (wd[ufc_pkg::QC_EN]) begin
              next_q.queue_enable_bit = 1'b1;
              next_q.trig_sel = wd[ufc_pkg::QC_TRIG_LO +: 2];
              tx_flush = wd[ufc_pkg::QC_TX_RST];
              rx_flush = wd[ufc_pkg::QC_RX_RST];
            end else begin
              next_q.queue_enable_bit = 1'b0;
            end
            if (!wd[ufc_pkg::QC_EN] || (next_q.queue_enable_bit != q.queue_enable_bit)) begin
              tx_flush = 1'b1;
              rx_flush = 1'b1;
            end
          end
          ufc_pkg::SEL_LINE: next_q.line_format_reg = wd;
          ufc_pkg::SEL_MASK: next_q.mask = wd[ufc_pkg::ST_W-1:0];
          default: ;
        endcase
      end
    end
    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready = !next_q.w_held && !next_q.bvalid;
    // Read channel: one outstanding read, data captured at acceptance
    if (q.rvalid && S_AXI_RREADY_I) begin
      next_q.rvalid = 1'b0;
    end
    rd_fire = S_AXI_ARVALID_I && q.arready;
    if (rd_fire) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = (rsel == ufc_pkg::SEL_NONE) ? ufc_pkg::RESP_SLVERR : ufc_pkg::RESP_OKAY;
      next_q.rdata = '0;
      case (rsel)
        ufc_pkg::SEL_DATA: begin
          if (q.line_format_reg[ufc_pkg::LF_DIV_ACCESS]) begin
            next_q.rdata[7:0] = q.div_lo;
          end else begin
            next_q.rdata[7:0] = rx_empty ? 8'h00 : rx_data;
            rx_pop = 1'b1;
          end
        end
        ufc_pkg::SEL_IRQ_EN: begin
          next_q.rdata[7:0] = q.line_format_reg[ufc_pkg::LF_DIV_ACCESS] ? q.div_hi
            : {4'h0, q.irq_enable_reg};
        end
        ufc_pkg::SEL_IDENT: next_q.rdata[7:0] = ident_reg;
        ufc_pkg::SEL_LINE: next_q.rdata[7:0] = q.line_format_reg;
        ufc_pkg::SEL_STATUS: next_q.rdata[ufc_pkg::ST_W-1:0] = q.status;
        ufc_pkg::SEL_MASK: next_q.rdata[ufc_pkg::ST_W-1:0] = q.mask;
        default: ;
      endcase
    end
    next_q.arready = !next_q.rvalid;
    // Transmitter shifts regardless of break
    case (q.tx_st)
      TX_IDLE: begin
        if (!tx_empty) begin
          tx_pop = 1'b1;
          next_q.tx_sh = {1'b1, tx_data, 1'b0};
          next_q.tx_bits = 4'(ufc_pkg::FRAME_BITS);
          next_q.tx_bcnt = '0;
          next_q.tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (q.tx_bcnt >= div_eff - 16'h0001) begin
          next_q.tx_bcnt = '0;
          next_q.tx_sh = {1'b1, q.tx_sh[ufc_pkg::FRAME_BITS-1:1]};
          next_q.tx_bits = q.tx_bits - 4'h1;
          if (q.tx_bits == 4'h1) begin
            next_q.tx_st = TX_IDLE;
          end
        end else begin
          next_q.tx_bcnt = q.tx_bcnt + 16'h0001;
        end
      end
      default: next_q.tx_st = TX_IDLE;
    endcase
    // Break only forces the pin
    next_q.ser_out = q.line_format_reg[ufc_pkg::LF_BREAK] ? 1'b0
      : ((q.tx_st == TX_SHIFT) ? q.tx_sh[0] : 1'b1);
    // Receiver: first sync stage feeds only the second
    next_q.rx_s1 = SERIAL_IN_PIN_I;
    next_q.rx_s2 = q.rx_s1;
    case (q.rx_st)
      RX_IDLE: begin
        if (!q.rx_s2) begin
          next_q.rx_bcnt = div_eff >> 1;
          next_q.rx_bits = '0;
          next_q.rx_st = RX_BITS;
        end
      end
      RX_BITS: begin
        if (q.rx_bcnt == 16'h0000) begin
          next_q.rx_bcnt = div_eff - 16'h0001;
          next_q.rx_bits = q.rx_bits + 4'h1;
          if (q.rx_bits == 4'h0) begin
            // Glitch on the start bit aborts the frame
            if (q.rx_s2) begin
              next_q.rx_st = RX_IDLE;
            end
          end else if (q.rx_bits <= 4'(ufc_pkg::DATA_BITS)) begin
            next_q.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
          end else begin
            next_q.rx_st = RX_IDLE;
            if (q.queue_enable_bit ? rx_full : !rx_empty) begin
              ev[ufc_pkg::ST_RX_OVR] = 1'b1;
            end else begin
              rx_push = 1'b1;
            end
          end
        end else begin
          next_q.rx_bcnt = q.rx_bcnt - 16'h0001;
        end
      end
      default: next_q.rx_st = RX_IDLE;
    endcase
    // Sticky events; a new event beats a same-cycle clear
    next_q.rx_level_d = rx_level;
    next_q.tx_empty_d = tx_empty;
    ev[ufc_pkg::ST_RX_TRIG] = rx_level && !q.rx_level_d;
    ev[ufc_pkg::ST_TX_EMPTY] = tx_empty && !q.tx_empty_d;
    next_q.status = q.status;
    if (wr_fire && wsel == ufc_pkg::SEL_STATUS && q.w_strb[0]) begin
      next_q.status = q.status & ~wd[ufc_pkg::ST_W-1:0];
    end
    next_q.status = next_q.status | ev;
    next_q.irq = |(next_q.status & next_q.mask);
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
      q.ser_out <= 1'b1;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.tx_empty_d <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign S_AXI_AWREADY_O = q.awready;
  assign S_AXI_WREADY_O = q.wready;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_ARREADY_O = q.arready;
  assign S_AXI_RVALID_O = q.rvalid;
  assign S_AXI_RDATA_O = q.rdata;
  assign S_AXI_RRESP_O = q.rresp;
  assign SERIAL_OUT_PIN_O = q.ser_out;
  assign IRQ_O = q.irq;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  a_qc_enable_set: assert property (wr_fire && wsel == ufc_pkg::SEL_IDENT && q.w_strb[0]
    && wd[ufc_pkg::QC_EN] |=> q.queue_enable_bit) else $error("queue enable not set");
  a_qc_guard_trig: assert property (wr_fire && wsel == ufc_pkg::SEL_IDENT
    && !wd[ufc_pkg::QC_EN] |=> $stable(q.trig_sel)) else $error("trigger changed w/o enable");
  a_trig_level_max: assert property (q.trig_sel == 2'b11 |-> trig == CW'(14))
    else $error("wrong top trigger level");
  a_tx_count_clear: assert property (tx_flush && !tx_push |=> tx_cnt == '0)
    else $error("tx counter not cleared");
  a_rx_count_clear: assert property (rx_flush |=> rx_cnt == '0)
    else $error("rx counter not cleared");
  a_mode_change_flush: assert property ($changed(q.queue_enable_bit)
    |-> $past(tx_flush) && $past(rx_flush)) else $error("mode change without flush");
  a_break_out_low: assert property (q.line_format_reg[ufc_pkg::LF_BREAK]
    |=> !SERIAL_OUT_PIN_O) else $error("break not driven");
  a_ident_top_bits: assert property (rd_fire && rsel == ufc_pkg::SEL_IDENT
    |=> S_AXI_RDATA_O[7:6] == {2{$past(q.queue_enable_bit)}}) else $error("ident bits 7:6");
  a_rx_avail_ident: assert property (q.queue_enable_bit && rx_cnt >= trig
    && q.irq_enable_reg[ufc_pkg::IE_RX] |-> ident == ufc_pkg::ID_RX_AVAIL)
    else $error("rx ident missing");
  a_line_readback: assert property (wr_fire && wsel == ufc_pkg::SEL_LINE && q.w_strb[0]
    |=> q.line_format_reg == $past(wd)) else $error("line format not stored");
  a_break_tx_runs: assert property (q.tx_st == TX_SHIFT && q.tx_bcnt == '0
    && q.tx_bits > 4'h1 ##1 q.line_format_reg[ufc_pkg::LF_BREAK] |-> q.tx_st == TX_SHIFT)
    else $error("tx halted by break");
  c_frame_sent: cover property (q.tx_st == TX_SHIFT ##1 q.tx_st == TX_IDLE);
  c_rx_push: cover property (rx_push);
  c_irq_up: cover property (!IRQ_O ##1 IRQ_O);
  c_fifo_on: cover property (q.queue_enable_bit && rx_level);
endmodule : ufc_top

// *** ufc_peer.sv ***
// Purpose: Remote serial terminal model, 8N1 in both directions
// Assumes: Bit time of DIV clock cycles, line idles high (mark)
// Notes: A break arrives as a zero byte; the receiver then waits for idle
`timescale 1ns/100ps
module ufc_peer #(
  parameter int DIV = 4
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o,
  output logic [7:0] rx_last_o,
  output int rx_cnt_o
);
  initial begin
    line_o = 1'b1;
    rx_last_o = 8'h00;
    rx_cnt_o = 0;
  end

  // Start, data LSB first, stop; each bit stands DIV cycles
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (DIV - 1) @(posedge clk_i);
    end
  endtask : send_byte

  // Mid-bit sampling tolerates the device's one-cycle pin lag
  always begin
    @(negedge clk_i);
    if (line_i === 1'b0) begin
      repeat (DIV / 2) @(negedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(negedge clk_i);
        rx_last_o[i] <= line_i;
      end
      repeat (DIV) @(negedge clk_i);
      rx_cnt_o <= rx_cnt_o + 1;
      wait (line_i === 1'b1);
    end
  end
endmodule : ufc_peer

// *** test_uart_fifo_and_line_control.sv ***
// Purpose: Self-checking bench for queue control, line format and break
// Assumes: Divisor 4, so one frame lasts 40 clock cycles
// Notes: Handshakes are judged at the falling edge, where registered outputs are settled
`timescale 1ns/100ps
module test_uart_fifo_and_line_control;
  logic clk;
  logic nrst;
  logic [ufc_pkg::ADDR_W-1:0] awaddr;
  logic [ufc_pkg::ADDR_W-1:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sin, ser_out, irq;
  logic [7:0] peer_byte;
  int peer_cnt;
  int num_errors;
  int total_checks;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [7:0] b0;
  logic [7:0] v;
  int lvl;
  int n;

  ufc_top u_dut (.SYS_CLK_I(clk), .NRST_I(nrst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .SERIAL_IN_PIN_I(sin), .SERIAL_OUT_PIN_O(ser_out), .IRQ_O(irq));
  ufc_peer #(.DIV(4)) u_peer (.clk_i(clk), .line_i(ser_out), .line_o(sin),
    .rx_last_o(peer_byte), .rx_cnt_o(peer_cnt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int trig_bytes(input logic [1:0] c);
    case (c)
      2'b00: return 1;
      2'b01: return 4;
      2'b10: return 8;
      default: return 14;
    endcase
  endfunction : trig_bytes

  // Only the receive interrupt is enabled, so no other source shows
  function automatic logic [31:0] ident(input logic en, input logic avail);
    return {24'h0, en, en, 2'b00, avail ? 3'b010 : 3'b000, ~avail};
  endfunction : ident

  task fail(input string m);
    num_errors++;
    $display("Error %0t ns: %s", $time, m);
  endtask : fail

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail(m);
    end
  endtask : chk

  task axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (tb !== 1'b1);
    // Only the watchdog ends a wait for the answer
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (tr !== 1'b1);
    rready <= 1'b0;
  endtask : axr

  task irq_chk(input logic e, input string m);
    // Receive push lands a few cycles after the peer's stop bit; sample off the edge
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e}, m);
  endtask : irq_chk

  task test_done();
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // About 2000 cycles are needed; the margin covers slow bus answers
  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    test_done();
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    seed = 32'h34d39e75;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    axr(ufc_pkg::OFS_LINE, rd, resp);
    chk(rd, 32'h0, "line format reset");
    axr(ufc_pkg::OFS_IDENT, rd, resp);
    chk(rd, ident(1'b0, 1'b0), "ident after reset");
    v = 8'(rnd()) & 8'h3f;
    axw(ufc_pkg::OFS_LINE, v, resp);
    axr(ufc_pkg::OFS_LINE, rd, resp);
    chk(rd, {24'h0, v}, "line format readback");
    axw(ufc_pkg::OFS_LINE, 8'h83, resp);
    axw(ufc_pkg::OFS_DATA, 8'h04, resp);
    axw(ufc_pkg::OFS_IRQ_EN, 8'h00, resp);
    axr(ufc_pkg::OFS_DATA, rd, resp);
    chk(rd, 32'h4, "divisor low");
    axw(ufc_pkg::OFS_LINE, 8'h03, resp);
    axw(ufc_pkg::OFS_IRQ_EN, 8'h01, resp);
    axr(ufc_pkg::OFS_IRQ_EN, rd, resp);
    chk(rd, 32'h1, "irq enable");
    axr(8'h1c, rd, resp);
    chk({rd[29:0], resp}, 32'h2, "unmapped read");
    axw(8'h1c, 8'hff, resp);
    chk({30'h0, resp}, 32'h2, "unmapped write");
    // Each level starts with a receive flush and random reserved bits
    for (int t = 0; t < 4; t++) begin
      v = 8'(rnd());
      axw(ufc_pkg::OFS_IDENT, {2'(t), v[2:0], 3'b111}, resp);
      lvl = trig_bytes(2'(t));
      for (int k = 1; k <= lvl; k++) begin
        v = 8'(rnd());
        if (k == 1) b0 = v;
        u_peer.send_byte(v);
        repeat (8) @(posedge clk);
        axr(ufc_pkg::OFS_IDENT, rd, resp);
        chk(rd, ident(1'b1, k >= lvl), "trigger level");
      end
      axr(ufc_pkg::OFS_DATA, rd, resp);
      chk(rd, {24'h0, b0}, "first queued byte");
      axr(ufc_pkg::OFS_IDENT, rd, resp);
      chk(rd, ident(1'b1, 1'b0), "below trigger after read");
    end
    axw(ufc_pkg::OFS_IDENT, 8'hc6, resp);
    axr(ufc_pkg::OFS_IDENT, rd, resp);
    chk(rd, ident(1'b0, 1'b0), "queues off and flushed");
    u_peer.send_byte(8'h5a);
    repeat (8) @(posedge clk);
    axr(ufc_pkg::OFS_IDENT, rd, resp);
    chk(rd, ident(1'b0, 1'b1), "single-byte hold");
    axw(ufc_pkg::OFS_IDENT, 8'h01, resp);
    axr(ufc_pkg::OFS_IDENT, rd, resp);
    chk(rd, ident(1'b1, 1'b0), "mode change flush");
    axw(ufc_pkg::OFS_STATUS, 8'h07, resp);
    axw(ufc_pkg::OFS_MASK, 8'h01, resp);
    u_peer.send_byte(8'ha5);
    irq_chk(1'b1, "irq raised");
    axw(ufc_pkg::OFS_MASK, 8'h00, resp);
    irq_chk(1'b0, "irq masked");
    axw(ufc_pkg::OFS_MASK, 8'h01, resp);
    irq_chk(1'b1, "irq unmasked");
    axw(ufc_pkg::OFS_STATUS, 8'h01, resp);
    irq_chk(1'b0, "irq cleared");
    n = peer_cnt;
    v = 8'(rnd());
    axw(ufc_pkg::OFS_DATA, v, resp);
    for (int i = 0; i < 100 && peer_cnt == n; i++) @(posedge clk);
    chk({peer_byte, 24'(peer_cnt - n)}, {v, 24'h1}, "byte sent on line");
    axw(ufc_pkg::OFS_LINE, 8'h43, resp);
    axw(ufc_pkg::OFS_DATA, 8'(rnd()), resp);
    lvl = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if (ser_out !== 1'b0) lvl++;
    end
    chk(32'(lvl), 32'h0, "break holds line low");
    axw(ufc_pkg::OFS_LINE, 8'h03, resp);
    repeat (2) @(posedge clk);
    lvl = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      if (ser_out !== 1'b1) lvl++;
    end
    chk(32'(lvl), 32'h0, "line idle after break");
    test_done();
  end
endmodule : test_uart_fifo_and_line_control
